// ===== lec_pkg.sv
// ==========================================================
// lookup engine control constants
// ==========================================================
package lec_pkg;

   // register indices; the byte address is four times the index
   localparam logic [9:0] LEC_IDX_MAC0 = 10'h302;
   localparam logic [9:0] LEC_IDX_CTL0 = 10'h310;
   localparam logic [9:0] LEC_IDX_CTL1 = 10'h311;
   localparam logic [9:0] LEC_IDX_CTL2 = 10'h312;
   localparam int LEC_MAC_BYTES = 6;
   localparam int LEC_AXI_AW = 12;

   // ==========================================================
   // reset values
   // ==========================================================
   localparam logic [7:0] LEC_CTL0_RST = 8'h61;
   localparam logic [7:0] LEC_CTL1_RST = 8'h0c;
   localparam logic [1:0] LEC_FLUSH_OPT_RST = 2'h0;
   localparam logic [47:0] LEC_MAC_RST = 48'h0010_a1ff_ffff;

   // ==========================================================
   // field positions
   // ==========================================================
   localparam int LEC_C0_VLAN_EN = 7;
   localparam int LEC_C0_DROP_INV_VID = 6;
   localparam int LEC_C0_AGE_HI = 5;
   localparam int LEC_C0_AGE_LO = 3;
   localparam int LEC_C0_RSVD_MC_EN = 2;
   localparam int LEC_C0_HASH_HI = 1;
   localparam int LEC_C0_HASH_LO = 0;
   localparam int LEC_C1_LEARN_DIS = 7;
   localparam int LEC_C1_SELF_FILT = 6;
   localparam int LEC_C1_FLUSH_ALL = 5;
   localparam int LEC_C1_FLUSH_MSTP = 4;
   localparam int LEC_C1_MC_SA_FWD = 3;
   localparam int LEC_C1_AGING_EN = 2;
   localparam int LEC_C1_FAST_AGING = 1;
   localparam int LEC_C1_LINK_FLUSH = 0;
   localparam int LEC_C2_FOPT_HI = 3;
   localparam int LEC_C2_FOPT_LO = 2;
   localparam int LEC_SA_GROUP_BIT = 40;

   // ==========================================================
   // encodings
   // ==========================================================
   localparam logic [1:0] LEC_HASH_CRC = 2'h1;
   localparam logic [1:0] LEC_HASH_XOR = 2'h2;
   localparam logic [1:0] LEC_FOPT_NONE = 2'h0;
   localparam logic [1:0] LEC_FOPT_DYN = 2'h1;
   localparam logic [1:0] LEC_FOPT_STATIC = 2'h2;
   localparam logic [1:0] LEC_FOPT_BOTH = 2'h3;
   localparam logic [1:0] LEC_RESP_OKAY = 2'h0;
   localparam logic [1:0] LEC_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {LEC_FK_ALL, LEC_FK_MSTP, LEC_FK_PORT} lec_fkind_t;

endpackage : lec_pkg

// ===== lec_flush_seq.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// flush sequencer: queues triggers, runs one flush at a time
// ==========================================================
module lec_flush_seq
   import lec_pkg::*;
#(
   parameter int NPORTS = 6
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic req_all,
   input wire logic req_mstp,
   input wire logic [NPORTS-1:0] req_port,
   input wire logic [1:0] flush_types,
   input wire logic flush_done,
   output logic flush_req,
   output lec_fkind_t flush_kind,
   output logic [1:0] flush_types_o,
   output logic [NPORTS-1:0] flush_port_map,
   output logic busy_all,
   output logic busy_mstp
);

   typedef enum logic {LEC_SQ_IDLE, LEC_SQ_RUN} lec_sq_t;

   lec_sq_t state_r;
   logic pend_all_r, pend_mstp_r;
   logic [NPORTS-1:0] pend_port_r;
   logic pick_all, pick_mstp, pick_port, idle_skip, done_now;
   logic fin_all, fin_mstp;
   logic [NPORTS-1:0] fin_port;

   always_comb begin
      pick_all = pend_all_r;
      pick_mstp = !pend_all_r && pend_mstp_r;
      pick_port = !pend_all_r && !pend_mstp_r && (|pend_port_r);
      // option none: trigger completes at once, nothing is flushed
      idle_skip = (state_r == LEC_SQ_IDLE) && (flush_types == LEC_FOPT_NONE);
      done_now = (state_r == LEC_SQ_RUN) && flush_done;
      fin_all = (idle_skip && pick_all) || (done_now && flush_kind == LEC_FK_ALL);
      fin_mstp = (idle_skip && pick_mstp) || (done_now && flush_kind == LEC_FK_MSTP);
      fin_port = '0;
      if (idle_skip && pick_port) begin
         fin_port = pend_port_r;
      end
      if (done_now && flush_kind == LEC_FK_PORT) begin
         fin_port = fin_port | flush_port_map;
      end
   end

   // a new trigger in the finishing cycle wins over the clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_all_r <= 1'b0;
         pend_mstp_r <= 1'b0;
         pend_port_r <= '0;
      end else begin
         pend_all_r <= req_all || (pend_all_r && !fin_all);
         pend_mstp_r <= req_mstp || (pend_mstp_r && !fin_mstp);
         pend_port_r <= req_port | (pend_port_r & ~fin_port);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= LEC_SQ_IDLE;
         flush_req <= 1'b0;
         flush_kind <= LEC_FK_ALL;
         flush_types_o <= LEC_FOPT_NONE;
         flush_port_map <= '0;
      end else begin
         case (state_r)
            LEC_SQ_IDLE: begin
               if (!idle_skip && (pick_all || pick_mstp || pick_port)) begin
                  state_r <= LEC_SQ_RUN;
                  flush_req <= 1'b1;
                  flush_types_o <= flush_types;
                  flush_port_map <= pick_port ? pend_port_r : '0;
                  flush_kind <= pick_all ? LEC_FK_ALL : (pick_mstp ? LEC_FK_MSTP : LEC_FK_PORT);
               end
            end
            LEC_SQ_RUN: begin
               if (flush_done) begin
                  state_r <= LEC_SQ_IDLE;
                  flush_req <= 1'b0;
               end
            end
            default: begin
               state_r <= LEC_SQ_IDLE;
               flush_req <= 1'b0;
            end
         endcase
      end
   end

   assign busy_all = pend_all_r;
   assign busy_mstp = pend_mstp_r;

endmodule : lec_flush_seq
`default_nettype wire

// ===== lec_lookup_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module lec_lookup_ctrl
   import lec_pkg::*;
#(
   parameter int NPORTS = 6,
   parameter int PORT_W = 3,
   parameter logic [9:0] CRC_POLY = 10'h233
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [LEC_AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [LEC_AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [NPORTS-1:0] link_up,
   input wire logic [NPORTS-1:0] port_self_filter_en,
   input wire logic unknown_vid_fwd_en,
   input wire logic pkt_valid,
   input wire logic [PORT_W-1:0] pkt_port,
   input wire logic [47:0] pkt_sa,
   input wire logic [47:0] pkt_da,
   input wire logic pkt_vid_invalid,
   output logic dec_valid,
   output logic dec_drop,
   output logic dec_to_host,
   output logic dec_unknown_vid,
   output logic dec_learn,
   output logic [9:0] dec_table_index,
   input wire logic flush_done,
   output logic flush_req,
   output lec_fkind_t flush_kind,
   output logic [1:0] flush_types,
   output logic [NPORTS-1:0] flush_port_map,
   output logic cfg_vlan_en,
   output logic [2:0] cfg_age_count,
   output logic cfg_rsvd_mcast_en,
   output logic [1:0] cfg_hash_select,
   output logic cfg_aging_en,
   output logic cfg_fast_aging,
   output logic [47:0] cfg_switch_mac
);

   // ==========================================================
   // register storage
   // ==========================================================
   logic [7:0] ctl0_r;
   logic [7:0] ctl1_r;
   logic [1:0] flush_opt_r;
   logic [7:0] mac_r [LEC_MAC_BYTES];
   logic busy_all, busy_mstp;

   // ==========================================================
   // axi4-lite write channel
   // ==========================================================
   logic aw_held_r, w_held_r;
   logic [LEC_AXI_AW-1:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic aw_take, w_take, wr_fire, aw_held_nxt, w_held_nxt, wr_lane0;
   logic wr_mapped;

   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take = s_axi_wvalid && s_axi_wready;
   // only one response outstanding: the write waits for bvalid to drop
   assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
   assign aw_held_nxt = aw_take || (aw_held_r && !wr_fire);
   assign w_held_nxt = w_take || (w_held_r && !wr_fire);
   assign wr_lane0 = wr_fire && w_strb_r[0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_addr_r <= '0;
         w_data_r <= '0;
         w_strb_r <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         aw_held_r <= aw_held_nxt;
         w_held_r <= w_held_nxt;
         s_axi_awready <= !aw_held_nxt;
         s_axi_wready <= !w_held_nxt;
         if (aw_take) begin
            aw_addr_r <= s_axi_awaddr;
         end
         if (w_take) begin
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
      end
   end

   always_comb begin
      wr_mapped = (aw_addr_r == {LEC_IDX_CTL0, 2'b00}) || (aw_addr_r == {LEC_IDX_CTL1, 2'b00})
         || (aw_addr_r == {LEC_IDX_CTL2, 2'b00});
      for (int i = 0; i < LEC_MAC_BYTES; i++) begin
         if (aw_addr_r == {10'(LEC_IDX_MAC0 + 10'(i)), 2'b00}) begin
            wr_mapped = 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= LEC_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_mapped ? LEC_RESP_OKAY : LEC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ==========================================================
   // control registers
   // ==========================================================
   logic wr_ctl0, wr_ctl1, wr_ctl2, trig_all, trig_mstp;

   assign wr_ctl0 = wr_lane0 && (aw_addr_r == {LEC_IDX_CTL0, 2'b00});
   assign wr_ctl1 = wr_lane0 && (aw_addr_r == {LEC_IDX_CTL1, 2'b00});
   assign wr_ctl2 = wr_lane0 && (aw_addr_r == {LEC_IDX_CTL2, 2'b00});
   // writing zero to a trigger cannot cancel a flush under way
   assign trig_all = wr_ctl1 && w_data_r[LEC_C1_FLUSH_ALL];
   assign trig_mstp = wr_ctl1 && w_data_r[LEC_C1_FLUSH_MSTP];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl0_r <= LEC_CTL0_RST;
         ctl1_r <= LEC_CTL1_RST;
         flush_opt_r <= LEC_FLUSH_OPT_RST;
      end else begin
         if (wr_ctl0) begin
            ctl0_r <= w_data_r[7:0];
         end
         if (wr_ctl1) begin
            ctl1_r <= w_data_r[7:0];
         end
         if (wr_ctl2) begin
            flush_opt_r <= w_data_r[LEC_C2_FOPT_HI:LEC_C2_FOPT_LO];
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < LEC_MAC_BYTES; g++) begin : g_mac
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               mac_r[g] <= LEC_MAC_RST[47-8*g -: 8];
            end else if (wr_lane0 && aw_addr_r == {10'(LEC_IDX_MAC0 + 10'(g)), 2'b00}) begin
               mac_r[g] <= w_data_r[7:0];
            end
         end
         // byte 0 lands in the top of the address
         assign cfg_switch_mac[47-8*g -: 8] = mac_r[g];
      end
   endgenerate

   // ==========================================================
   // axi4-lite read channel
   // ==========================================================
   logic ar_take;
   logic [7:0] rd_byte;
   logic rd_hit;

   assign ar_take = s_axi_arvalid && s_axi_arready;

   always_comb begin
      rd_byte = 8'h00;
      rd_hit = 1'b1;
      case (s_axi_araddr)
         {LEC_IDX_CTL0, 2'b00}: rd_byte = ctl0_r;
         {LEC_IDX_CTL1, 2'b00}: begin
            rd_byte = ctl1_r;
            rd_byte[LEC_C1_FLUSH_ALL] = busy_all;
            rd_byte[LEC_C1_FLUSH_MSTP] = busy_mstp;
         end
         {LEC_IDX_CTL2, 2'b00}: rd_byte[LEC_C2_FOPT_HI:LEC_C2_FOPT_LO] = flush_opt_r;
         default: rd_hit = 1'b0;
      endcase
      for (int i = 0; i < LEC_MAC_BYTES; i++) begin
         if (s_axi_araddr == {10'(LEC_IDX_MAC0 + 10'(i)), 2'b00}) begin
            rd_byte = mac_r[i];
            rd_hit = 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= LEC_RESP_OKAY;
         s_axi_arready <= 1'b0;
      end else begin
         if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_hit ? LEC_RESP_OKAY : LEC_RESP_SLVERR;
            s_axi_arready <= 1'b0;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ==========================================================
   // link-down detection
   // ==========================================================
   logic [NPORTS-1:0] link_meta_r, link_sync_r, link_last_r, link_lost;

   generate
      for (g = 0; g < NPORTS; g++) begin : g_link
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               link_meta_r[g] <= 1'b0;
               link_sync_r[g] <= 1'b0;
               link_last_r[g] <= 1'b0;
            end else begin
               link_meta_r[g] <= link_up[g];
               link_sync_r[g] <= link_meta_r[g];
               link_last_r[g] <= link_sync_r[g];
            end
         end
         assign link_lost[g] = link_last_r[g] && !link_sync_r[g] && ctl1_r[LEC_C1_LINK_FLUSH];
      end
   endgenerate

   lec_flush_seq #(
      .NPORTS(NPORTS)
   ) u_seq (
      .aclk(aclk),
      .aresetn(aresetn),
      .req_all(trig_all),
      .req_mstp(trig_mstp),
      .req_port(link_lost),
      .flush_types(flush_opt_r),
      .flush_done(flush_done),
      .flush_req(flush_req),
      .flush_kind(flush_kind),
      .flush_types_o(flush_types),
      .flush_port_map(flush_port_map),
      .busy_all(busy_all),
      .busy_mstp(busy_mstp)
   );

   // ==========================================================
   // per-packet decision, one registered stage
   // ==========================================================
   function automatic logic [9:0] lec_crc10(input logic [47:0] d);
      logic [9:0] c;
      c = '1;
      for (int i = 47; i >= 0; i--) begin
         c = {c[8:0], 1'b0} ^ ((c[9] ^ d[i]) ? CRC_POLY : 10'h000);
      end
      return c;
   endfunction : lec_crc10

   logic vid_bad, unk_vid, sa_group, self_hit, drop_now;
   logic [9:0] index_now;

   always_comb begin
      vid_bad = ctl0_r[LEC_C0_VLAN_EN] && pkt_vid_invalid;
      unk_vid = vid_bad && unknown_vid_fwd_en;
      sa_group = pkt_sa[LEC_SA_GROUP_BIT];
      self_hit = ctl1_r[LEC_C1_SELF_FILT] && (pkt_port < PORT_W'(NPORTS))
         && port_self_filter_en[pkt_port] && (pkt_sa == cfg_switch_mac);
      drop_now = self_hit || (sa_group && !ctl1_r[LEC_C1_MC_SA_FWD])
         || (vid_bad && !unk_vid && ctl0_r[LEC_C0_DROP_INV_VID]);
      case (ctl0_r[LEC_C0_HASH_HI:LEC_C0_HASH_LO])
         LEC_HASH_CRC: index_now = lec_crc10(pkt_da);
         LEC_HASH_XOR: index_now = pkt_da[9:0] ^ pkt_da[19:10] ^ pkt_da[29:20] ^ pkt_da[39:30]
            ^ {2'b00, pkt_da[47:40]};
         default: index_now = pkt_da[9:0];
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dec_valid <= 1'b0;
         dec_drop <= 1'b0;
         dec_to_host <= 1'b0;
         dec_unknown_vid <= 1'b0;
         dec_learn <= 1'b0;
         dec_table_index <= '0;
      end else begin
         dec_valid <= pkt_valid;
         dec_drop <= pkt_valid && drop_now;
         dec_to_host <= pkt_valid && !drop_now && vid_bad && !unk_vid;
         dec_unknown_vid <= pkt_valid && unk_vid;
         dec_learn <= pkt_valid && !drop_now && !sa_group && !ctl1_r[LEC_C1_LEARN_DIS];
         dec_table_index <= index_now;
      end
   end

   // ==========================================================
   // settings for the lookup engine
   // ==========================================================
   assign cfg_vlan_en = ctl0_r[LEC_C0_VLAN_EN];
   assign cfg_age_count = ctl0_r[LEC_C0_AGE_HI:LEC_C0_AGE_LO];
   assign cfg_rsvd_mcast_en = ctl0_r[LEC_C0_RSVD_MC_EN];
   assign cfg_hash_select = ctl0_r[LEC_C0_HASH_HI:LEC_C0_HASH_LO];
   assign cfg_aging_en = ctl1_r[LEC_C1_AGING_EN];
   assign cfg_fast_aging = ctl1_r[LEC_C1_FAST_AGING];

endmodule : lec_lookup_ctrl
`default_nettype wire

// ===== lec_lookup_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checks for the lookup control block
// ==========================================================
module lec_lookup_ctrl_properties
   import lec_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic unknown_vid_fwd_en,
   input wire logic pkt_valid,
   input wire logic [47:0] pkt_da,
   input wire logic pkt_vid_invalid,
   input wire logic dec_valid,
   input wire logic dec_drop,
   input wire logic dec_to_host,
   input wire logic dec_unknown_vid,
   input wire logic dec_learn,
   input wire logic [9:0] dec_table_index,
   input wire logic flush_done,
   input wire logic flush_req,
   input wire lec_fkind_t flush_kind,
   input wire logic [1:0] flush_types,
   input wire logic cfg_vlan_en,
   input wire logic [1:0] cfg_hash_select
);
   // low address bits seen one edge back, for the direct index
   logic [9:0] da_low_r;
   always_ff @(posedge aclk) begin
      da_low_r <= pkt_da[9:0];
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_write_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_write_answered;
      ##[1:4] s_axi_bvalid;
   endsequence
   sequence s_vid_bad;
      pkt_valid && pkt_vid_invalid && cfg_vlan_en;
   endsequence
   chk_write_answer: assert property (s_write_taken |-> s_write_answered) else $error("write answer late");
   chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("address taken during read");
   chk_dec_pulse: assert property (pkt_valid |=> dec_valid ##1 (dec_valid == $past(pkt_valid)))
      else $error("decision timing wrong");
   chk_learn_drop: assert property (dec_valid && dec_learn |-> !dec_drop) else $error("learned a dropped packet");
   chk_vlan_off: assert property (pkt_valid && !cfg_vlan_en |=> !dec_to_host && !dec_unknown_vid)
      else $error("vlan action while disabled");
   chk_inv_vid: assert property (s_vid_bad ##0 !unknown_vid_fwd_en |=> (dec_drop || dec_to_host) && !dec_unknown_vid)
      else $error("invalid vid not handled");
   chk_unk_vid: assert property (s_vid_bad ##0 unknown_vid_fwd_en |=> dec_unknown_vid && !dec_to_host)
      else $error("unknown vid not preferred");
   chk_direct_idx: assert property (pkt_valid && cfg_hash_select inside {2'h0, 2'h3} |=> dec_table_index == da_low_r)
      else $error("direct index wrong");
   chk_flush_hold: assert property (flush_req && !flush_done |=> flush_req && $stable(flush_kind) && $stable(flush_types))
      else $error("flush request unstable");
   chk_flush_types: assert property ($rose(flush_req) |-> flush_types != LEC_FOPT_NONE) else $error("empty flush ran");
   chk_flush_end: assert property (flush_req && flush_done |=> !flush_req) else $error("flush not ended");
endmodule : lec_lookup_ctrl_properties

bind lec_lookup_ctrl lec_lookup_ctrl_properties u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .unknown_vid_fwd_en, .pkt_valid, .pkt_da, .pkt_vid_invalid, .dec_valid, .dec_drop, .dec_to_host,
   .dec_unknown_vid, .dec_learn, .dec_table_index, .flush_done, .flush_req, .flush_kind, .flush_types, .cfg_vlan_en,
   .cfg_hash_select);
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
   import lec_pkg::*;
;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [31:0] wdata = 32'h0;
   logic pv = 1'h0, vinv = 1'h0, unk = 1'h0, fdone = 1'h0;
   logic [2:0] pport = 3'h0;
   logic [47:0] psa = 48'h0;
   logic [5:0] lup = 6'h3f, pfe = 6'h02;
   logic awready, wready, bvalid, arready, rvalid, dv, ddrop, dhost, dunk, dlearn, freq, vlan, rsvd, aging, fast;
   logic [1:0] bresp, rresp, ftypes, hash;
   logic [31:0] rdata;
   logic [9:0] idx;
   lec_fkind_t fkind;
   logic [5:0] fmap;
   logic [2:0] age;
   logic [47:0] mac;
   int err_total = 0;
   int tests_run = 0;

   lec_lookup_ctrl u_lec_lookup_ctrl (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .link_up(lup), .port_self_filter_en(pfe), .unknown_vid_fwd_en(unk), .pkt_valid(pv), .pkt_port(pport),
      .pkt_sa(psa), .pkt_da(48'h1234_5678_9abc), .pkt_vid_invalid(vinv), .dec_valid(dv), .dec_drop(ddrop),
      .dec_to_host(dhost), .dec_unknown_vid(dunk), .dec_learn(dlearn), .dec_table_index(idx), .flush_done(fdone),
      .flush_req(freq), .flush_kind(fkind), .flush_types(ftypes), .flush_port_map(fmap), .cfg_vlan_en(vlan),
      .cfg_age_count(age), .cfg_rsvd_mcast_en(rsvd), .cfg_hash_select(hash), .cfg_aging_en(aging),
      .cfg_fast_aging(fast), .cfg_switch_mac(mac)
   );

   initial begin
      forever #50 aclk = ~aclk;
   end

   // ==========================================================
   // reporting
   // ==========================================================
   task chk(input logic [47:0] got, input logic [47:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish

   task expired;
      err_total++;
      $display("MISMATCH t=%0t wait expired", $time);
      tally_and_finish();
   endtask : expired

   // ==========================================================
   // bus cycles; readies and answers sampled at the edge
   // ==========================================================
   task wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         n++;
         if (n > 50) expired();
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (!bvalid);
      bready <= 1'h0;
      chk(48'(bresp), 48'(er));
   endtask : wr

   task rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge aclk);
         n++;
         if (n > 50) expired();
         if (arready) arvalid <= 1'h0;
      end while (!rvalid);
      rready <= 1'h0;
      chk(48'({rresp, rdata}), 48'({er, 24'h0, d}));
   endtask : rd

   // one packet; decision flags then table index
   task pkt(input logic [2:0] p, input logic [47:0] s, input logic v, input logic u, input logic [14:0] exp);
      @(posedge aclk);
      pv <= 1'h1;
      pport <= p;
      psa <= s;
      vinv <= v;
      unk <= u;
      @(posedge aclk);
      pv <= 1'h0;
      #1 chk(48'({dv, ddrop, dhost, dunk, dlearn, idx}), 48'(exp));
   endtask : pkt

   task wait_flush;
      int n;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (n > 20) expired();
      end while (!freq);
   endtask : wait_flush

   task finish_flush;
      @(posedge aclk);
      fdone <= 1'h1;
      @(posedge aclk);
      fdone <= 1'h0;
   endtask : finish_flush

   // ==========================================================
   // scenarios
   // ==========================================================
   task t_reset;
      rd(12'hc40, 8'h61, LEC_RESP_OKAY);
      rd(12'hc44, 8'h0c, LEC_RESP_OKAY);
      rd(12'hc48, 8'h00, LEC_RESP_OKAY);
      rd(12'hc08, 8'h00, LEC_RESP_OKAY);
      chk(48'({vlan, age, rsvd, hash, aging, fast}), 48'({1'h0, 3'h4, 1'h0, 2'h1, 1'h1, 1'h0}));
   endtask : t_reset

   task t_cfg;
      wr(12'hc40, 8'h9e, LEC_RESP_OKAY);
      rd(12'hc40, 8'h9e, LEC_RESP_OKAY);
      chk(48'({vlan, age, rsvd, hash}), 48'({1'h1, 3'h3, 1'h1, 2'h2}));
      wr(12'hc44, 8'h82, LEC_RESP_OKAY);
      chk(48'({aging, fast}), 48'h1);
      // unmapped place: write ignored, reads zero
      wr(12'hc80, 8'h55, LEC_RESP_SLVERR);
      rd(12'hc80, 8'h00, LEC_RESP_SLVERR);
      for (int i = 0; i < LEC_MAC_BYTES; i++) begin
         wr(12'hc08 + 12'(4 * i), 8'h02 + 8'(4 * i), LEC_RESP_OKAY);
      end
      chk(mac, 48'h0206_0a0e_1216);
   endtask : t_cfg

   task t_decide;
      wr(12'hc40, 8'h80, LEC_RESP_OKAY);
      wr(12'hc44, 8'h44, LEC_RESP_OKAY);
      pkt(3'h0, 48'h0200_0000_0001, 1'h1, 1'h0, {5'h15, 10'h2bc});
      pkt(3'h0, 48'h0200_0000_0001, 1'h1, 1'h1, {5'h13, 10'h2bc});
      pkt(3'h0, 48'h0100_0000_0001, 1'h0, 1'h0, {5'h18, 10'h2bc});
      pkt(3'h1, 48'h0206_0a0e_1216, 1'h0, 1'h0, {5'h18, 10'h2bc});
      pkt(3'h2, 48'h0206_0a0e_1216, 1'h0, 1'h0, {5'h11, 10'h2bc});
      wr(12'hc44, 8'hcc, LEC_RESP_OKAY);
      pkt(3'h0, 48'h0100_0000_0001, 1'h0, 1'h0, {5'h10, 10'h2bc});
      pkt(3'h0, 48'h0200_0000_0001, 1'h0, 1'h0, {5'h10, 10'h2bc});
      wr(12'hc40, 8'h03, LEC_RESP_OKAY);
      pkt(3'h0, 48'h0200_0000_0001, 1'h1, 1'h1, {5'h10, 10'h2bc});
      wr(12'hc40, 8'h02, LEC_RESP_OKAY);
      pkt(3'h0, 48'h2, 1'h0, 1'h0, {5'h10, 10'h13e});
   endtask : t_decide

   task t_flush;
      wr(12'hc48, 8'h04, LEC_RESP_OKAY);
      wr(12'hc44, 8'h2c, LEC_RESP_OKAY);
      wait_flush();
      chk(48'({fkind, ftypes}), 48'({LEC_FK_ALL, LEC_FOPT_DYN}));
      rd(12'hc44, 8'h2c, LEC_RESP_OKAY);
      finish_flush();
      rd(12'hc44, 8'h0c, LEC_RESP_OKAY);
      wr(12'hc48, 8'h0c, LEC_RESP_OKAY);
      wr(12'hc44, 8'h1c, LEC_RESP_OKAY);
      wait_flush();
      chk(48'({fkind, ftypes}), 48'({LEC_FK_MSTP, LEC_FOPT_BOTH}));
      finish_flush();
      rd(12'hc44, 8'h0c, LEC_RESP_OKAY);
      wr(12'hc44, 8'h0d, LEC_RESP_OKAY);
      lup <= 6'h3b;
      wait_flush();
      chk({fkind, fmap}, {LEC_FK_PORT, 6'h04});
      finish_flush();
      lup <= 6'h3f;
      // empty option: trigger retires at once; link loss now ignored
      wr(12'hc48, 8'h00, LEC_RESP_OKAY);
      wr(12'hc44, 8'h2c, LEC_RESP_OKAY);
      lup <= 6'h3e;
      repeat (8) @(posedge aclk);
      chk(48'(freq), 48'h0);
      rd(12'hc44, 8'h0c, LEC_RESP_OKAY);
   endtask : t_flush

   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      t_reset();
      t_cfg();
      t_decide();
      t_flush();
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
